/* File: hw/dmres_pkg.sv */
// dmres_pkg: constants for the diagnostic monitor result register bank.
// assumes: byte-wide register port, one system clock, 12-bit converter results.
package dmres_pkg;

  // widths of the port and of a conversion result
  localparam int ADDR_W   = 8;
  localparam int DATA_W   = 8;
  localparam int RES_W    = 12;
  localparam int CHAN_W   = 4;
  localparam int NUM_SRC  = 9;

  // field positions inside a result and inside a low register
  localparam int RES_HIGH_MSB = 11;
  localparam int RES_HIGH_LSB = 4;
  localparam int RES_LOW_MSB  = 3;
  localparam int LOW_NIB_MSB  = 7;
  localparam int LOW_NIB_LSB  = 4;
  localparam int LOW_ID_MSB   = 3;

  // high register offsets; each low register sits at high offset plus one
  localparam logic [7:0] MIC_BIAS_HIGH_OFS      = 8'h58;
  localparam logic [7:0] MIC_BIAS_LOW_OFS       = 8'h59;
  localparam logic [7:0] OUT1_POS_HIGH_OFS      = 8'h62;
  localparam logic [7:0] OUT1_POS_LOW_OFS       = 8'h63;
  localparam logic [7:0] OUT1_NEG_HIGH_OFS      = 8'h64;
  localparam logic [7:0] OUT1_NEG_LOW_OFS       = 8'h65;
  localparam logic [7:0] OUT2_POS_HIGH_OFS      = 8'h66;
  localparam logic [7:0] OUT2_POS_LOW_OFS       = 8'h67;
  localparam logic [7:0] OUT2_NEG_HIGH_OFS      = 8'h68;
  localparam logic [7:0] OUT2_NEG_LOW_OFS       = 8'h69;
  localparam logic [7:0] THERMAL_HIGH_OFS       = 8'h6A;
  localparam logic [7:0] THERMAL_LOW_OFS        = 8'h6B;
  localparam logic [7:0] BIAS_LOAD_HIGH_OFS     = 8'h6C;
  localparam logic [7:0] BIAS_LOAD_LOW_OFS      = 8'h6D;
  localparam logic [7:0] ANALOG_SUPPLY_HIGH_OFS = 8'h6E;
  localparam logic [7:0] ANALOG_SUPPLY_LOW_OFS  = 8'h6F;
  localparam logic [7:0] GP_ANALOG_HIGH_OFS     = 8'h70;
  localparam logic [7:0] GP_ANALOG_LOW_OFS      = 8'h71;

  // fixed source identifiers carried in each low register
  localparam logic [3:0] MIC_BIAS_ID      = 4'h1;
  localparam logic [3:0] OUT1_POS_ID      = 4'h6;
  localparam logic [3:0] OUT1_NEG_ID      = 4'h7;
  localparam logic [3:0] OUT2_POS_ID      = 4'h8;
  localparam logic [3:0] OUT2_NEG_ID      = 4'h9;
  localparam logic [3:0] THERMAL_ID       = 4'hA;
  localparam logic [3:0] BIAS_LOAD_ID     = 4'hB;
  localparam logic [3:0] ANALOG_SUPPLY_ID = 4'hC;
  localparam logic [3:0] GP_ANALOG_ID     = 4'hD;

  // reset values: results clear, low register shows only its identifier
  localparam logic [11:0] RESULT_RESET    = 12'h000;
  localparam logic [7:0]  HIGH_RESET      = 8'h00;
  localparam logic [3:0]  LOW_NIB_RESET   = 4'h0;
  localparam logic [7:0]  UNMAPPED_READ   = 8'h00;

  // slot tables, index order is the register order
  localparam logic [7:0] SLOT_HIGH_OFS [NUM_SRC] = '{
    MIC_BIAS_HIGH_OFS, OUT1_POS_HIGH_OFS, OUT1_NEG_HIGH_OFS,
    OUT2_POS_HIGH_OFS, OUT2_NEG_HIGH_OFS, THERMAL_HIGH_OFS,
    BIAS_LOAD_HIGH_OFS, ANALOG_SUPPLY_HIGH_OFS, GP_ANALOG_HIGH_OFS};
  localparam logic [7:0] SLOT_LOW_OFS [NUM_SRC] = '{
    MIC_BIAS_LOW_OFS, OUT1_POS_LOW_OFS, OUT1_NEG_LOW_OFS,
    OUT2_POS_LOW_OFS, OUT2_NEG_LOW_OFS, THERMAL_LOW_OFS,
    BIAS_LOAD_LOW_OFS, ANALOG_SUPPLY_LOW_OFS, GP_ANALOG_LOW_OFS};
  localparam logic [3:0] SLOT_ID [NUM_SRC] = '{
    MIC_BIAS_ID, OUT1_POS_ID, OUT1_NEG_ID, OUT2_POS_ID, OUT2_NEG_ID,
    THERMAL_ID, BIAS_LOAD_ID, ANALOG_SUPPLY_ID, GP_ANALOG_ID};

endpackage : dmres_pkg

/* File: hw/dmres_capture.sv */
// dmres_capture: registers one converter result and checks its channel tag.
// assumes: result inputs come from converter logic on the same clock.
`timescale 1ns/1ps
module dmres_capture (
  input  wire logic        clk_sys_i,
  input  wire logic        reset_i,
  input  wire logic        result_valid_i,
  input  wire logic [3:0]  result_chan_i,
  input  wire logic [11:0] result_data_i,
  output logic             cap_valid_o,
  output logic [3:0]       cap_chan_o,
  output logic [11:0]      cap_data_o,
  output logic             cap_stray_o
);

  // known channel tag on the incoming result
  logic known_chan;

  // match the tag against every source identifier
  always_comb begin
    known_chan = 1'b0;
    for (int i = 0; i < dmres_pkg::NUM_SRC; i++) begin
      if (result_chan_i == dmres_pkg::SLOT_ID[i]) begin
        known_chan = 1'b1;
      end
    end
  end

  // one stage of capture so slots see a clean, aligned word
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      cap_valid_o <= 1'b0;
      cap_chan_o  <= 4'h0;
      cap_data_o  <= dmres_pkg::RESULT_RESET;
      cap_stray_o <= 1'b0;
    end else begin
      cap_valid_o <= result_valid_i & known_chan;
      cap_chan_o  <= result_chan_i;
      cap_data_o  <= result_data_i;
      // a tag that names no register is dropped and reported
      cap_stray_o <= result_valid_i & ~known_chan;
    end
  end

endmodule : dmres_capture

/* File: hw/dmres_slot.sv */
// dmres_slot: holds the latest 12-bit result of one monitored source.
// assumes: load strobe already qualified by channel match and freeze.
`timescale 1ns/1ps
module dmres_slot #(
  parameter logic [3:0] CHAN_ID = 4'h0
) (
  input  wire logic        clk_sys_i,
  input  wire logic        reset_i,
  input  wire logic        load_i,
  input  wire logic [11:0] data_i,
  output logic [7:0]       high_byte_o,
  output logic [7:0]       low_byte_o
);

  // stored result, cleared by reset
  logic [11:0] result;

  // result store, read-only from the host side
  // results clear on reset
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      result <= dmres_pkg::RESULT_RESET;
    end else if (load_i) begin
      result <= data_i;
    end
  end

  assign high_byte_o = result[dmres_pkg::RES_HIGH_MSB:dmres_pkg::RES_HIGH_LSB];
  assign low_byte_o  = {result[dmres_pkg::RES_LOW_MSB:0], CHAN_ID};

endmodule : dmres_slot

/* File: hw/dmres_bank.sv */
// dmres_bank: read-only bank of diagnostic monitor result registers.
// assumes: byte register port and converter on the same clock; freeze level
// comes from a control register elsewhere in the unit.
`timescale 1ns/1ps
// Contract
// - high register holds result bits 11..4
// - low register bits 7..4 hold bits 3..0
// - mic bias low identifier 0001, resets 0x01
// - out1 positive low identifier 0110, resets 0x06
// - out1 negative low identifier 0111, resets 0x07
// - out2 positive low identifier 1000, resets 0x08
// - out2 negative low identifier 1001, resets 0x09
// - thermal low identifier 1010, resets 0x0A
// - bias load low identifier 1011, resets 0x0B
// - analog supply low identifier 1100, resets 0x0C
// - all high registers reset to 0x00
// - general analog low identifier 1101, resets 0x0D
// - freeze set stops updates; clear resumes
// - mic bias high at 0x58, resets 0x00
module dmres_bank (
  input  wire logic        clk_sys_i,
  input  wire logic        reset_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic        reg_rd_i,
  input  wire logic        reg_wr_i,
  input  wire logic [7:0]  reg_wdata_i,
  output logic [7:0]       reg_rdata_o,
  output logic             reg_ack_o,
  output logic             reg_hit_o,
  input  wire logic        freeze_monitor_results_i,
  input  wire logic        result_valid_i,
  input  wire logic [3:0]  result_chan_i,
  input  wire logic [11:0] result_data_i,
  output logic             results_held_o,
  output logic             stray_result_o
);

  // captured converter word
  logic        cap_valid;
  logic [3:0]  cap_chan;
  logic [11:0] cap_data;
  logic        cap_stray;
  // per-source register images
  logic [7:0]  high_byte [dmres_pkg::NUM_SRC];
  logic [7:0]  low_byte  [dmres_pkg::NUM_SRC];
  logic [dmres_pkg::NUM_SRC-1:0] slot_load;
  // read decode
  logic [7:0]  next_rdata;
  logic        next_hit;
  // write data is accepted and discarded
  logic        wr_seen;

  // input stage
  dmres_capture u_capture (
    .clk_sys_i      (clk_sys_i),
    .reset_i        (reset_i),
    .result_valid_i (result_valid_i),
    .result_chan_i  (result_chan_i),
    .result_data_i  (result_data_i),
    .cap_valid_o    (cap_valid),
    .cap_chan_o     (cap_chan),
    .cap_data_o     (cap_data),
    .cap_stray_o    (cap_stray)
  );

  // one slot per monitored source; identifiers fix the low reset values
  for (genvar g = 0; g < dmres_pkg::NUM_SRC; g++) begin : g_slot
    assign slot_load[g] = cap_valid & ~freeze_monitor_results_i
                          & (cap_chan == dmres_pkg::SLOT_ID[g]);
    dmres_slot #(
      .CHAN_ID (dmres_pkg::SLOT_ID[g])
    ) u_slot (
      .clk_sys_i   (clk_sys_i),
      .reset_i     (reset_i),
      .load_i      (slot_load[g]),
      .data_i      (cap_data),
      .high_byte_o (high_byte[g]),
      .low_byte_o  (low_byte[g])
    );
  end

  // address decode over all high and low offsets
  always_comb begin
    next_rdata = dmres_pkg::UNMAPPED_READ;
    next_hit   = 1'b0;
    for (int i = 0; i < dmres_pkg::NUM_SRC; i++) begin
      // high offset table starts at 0x58
      if (reg_addr_i == dmres_pkg::SLOT_HIGH_OFS[i]) begin
        next_rdata = high_byte[i];
        next_hit   = 1'b1;
      end
      // identifier nibble shown for host to strip
      if (reg_addr_i == dmres_pkg::SLOT_LOW_OFS[i]) begin
        next_rdata = low_byte[i];
        next_hit   = 1'b1;
      end
    end
  end

  // read data and answer, one cycle after the strobe
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      reg_rdata_o <= dmres_pkg::HIGH_RESET;
      reg_hit_o   <= 1'b0;
    end else if (reg_rd_i) begin
      reg_rdata_o <= next_rdata;
      reg_hit_o   <= next_hit;
    end else if (wr_seen) begin
      // write answered with zero data, contents untouched
      reg_rdata_o <= dmres_pkg::UNMAPPED_READ;
      reg_hit_o   <= next_hit;
    end
  end

  // answer strobe for either access
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      reg_ack_o <= 1'b0;
    end else begin
      reg_ack_o <= reg_rd_i | reg_wr_i;
    end
  end

  assign wr_seen = reg_wr_i & (|reg_wdata_i | 1'b1);

  // status outputs
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      results_held_o <= 1'b0;
      stray_result_o <= 1'b0;
    end else begin
      results_held_o <= freeze_monitor_results_i;
      stray_result_o <= cap_stray;
    end
  end

endmodule : dmres_bank

/* File: tb/dmres_bank_properties.sv */
// dmres_bank_properties: port checks on the result register bank.
// assumes: bound to dmres_bank, one clock, reset active high.
`timescale 1ns/1ps
module dmres_bank_properties (
  input wire logic        clk_sys_i,
  input wire logic        reset_i,
  input wire logic [7:0]  reg_addr_i,
  input wire logic        reg_rd_i,
  input wire logic        reg_wr_i,
  input wire logic [7:0]  reg_wdata_i,
  input wire logic [7:0]  reg_rdata_o,
  input wire logic        reg_ack_o,
  input wire logic        reg_hit_o,
  input wire logic        freeze_monitor_results_i,
  input wire logic        result_valid_i,
  input wire logic [3:0]  result_chan_i,
  input wire logic [11:0] result_data_i,
  input wire logic        results_held_o,
  input wire logic        stray_result_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  // out1 positive result taken, then loaded with freeze low
  sequence s_load6;
    result_valid_i && result_chan_i == 4'h6 ##1 !result_valid_i && !freeze_monitor_results_i;
  endsequence
  AST_ACK: assert property ((reg_rd_i || reg_wr_i) |=> reg_ack_o)
    else $error("no answer after strobe");
  AST_WR: assert property ((reg_wr_i && !reg_rd_i) |=> reg_rdata_o == 8'h00)
    else $error("write returned data");
  AST_MBID: assert property ((reg_rd_i && reg_addr_i == 8'h59) |=> reg_rdata_o[3:0] == 4'h1)
    else $error("mic bias id wrong");
  AST_GPID: assert property ((reg_rd_i && reg_addr_i == 8'h71) |=> reg_rdata_o[3:0] == 4'hD)
    else $error("general analog id wrong");
  AST_MBHI: assert property ((reg_rd_i && reg_addr_i == 8'h58) |=> reg_hit_o)
    else $error("mic bias high not mapped");
  AST_HELD: assert property (1'b1 |=> results_held_o == $past(freeze_monitor_results_i))
    else $error("held flag wrong");
  AST_HI: assert property (s_load6 ##1 (reg_rd_i && reg_addr_i == 8'h62) |=>
    {reg_rdata_o, 4'h0} == ($past(result_data_i, 3) & 12'hFF0))
    else $error("high byte wrong");
  AST_LO: assert property (s_load6 ##1 (reg_rd_i && reg_addr_i == 8'h63) |=>
    {4'h0, reg_rdata_o} == ((($past(result_data_i, 3) & 12'h00F) << 4) | 12'h006))
    else $error("low byte wrong");
endmodule : dmres_bank_properties
bind dmres_bank dmres_bank_properties u_props (.*);

/* File: tb/dmres_host.sv */
// dmres_host: host model reading the bank over the byte strobe port.
// assumes: one-cycle strobe, answer registered on the taking edge and sampled 1 ns after it.
`timescale 1ns/1ps
module dmres_host (
  input  wire logic       clk_sys_i,
  output logic      [7:0] reg_addr_o,
  output logic            reg_rd_o,
  output logic            reg_wr_o,
  output logic      [7:0] reg_wdata_o,
  input  wire logic [7:0] reg_rdata_i,
  input  wire logic       reg_ack_i
);
  // idle port at time zero
  initial begin
    reg_addr_o  = 8'h00;
    reg_rd_o    = 1'b0;
    reg_wr_o    = 1'b0;
    reg_wdata_o = 8'h00;
  end
  // one access, answer sampled once, one cycle after the strobe
  task automatic acc(input bit w, input logic [7:0] a, input logic [7:0] wd,
                     output logic [7:0] d, output bit ok);
    @(posedge clk_sys_i);
    #1;
    reg_addr_o  = a;
    reg_wdata_o = wd;
    reg_rd_o    = !w;
    reg_wr_o    = w;
    @(posedge clk_sys_i);
    #1;
    reg_rd_o = 1'b0;
    reg_wr_o = 1'b0;
    ok = reg_ack_i === 1'b1;
    d  = reg_rdata_i;
  endtask : acc
  function automatic logic [11:0] rebuild(input logic [7:0] h, input logic [7:0] l);
    return {h, l[7:4]};
  endfunction : rebuild
endmodule : dmres_host

/* File: tb/tb_dmres_bank.sv */
// tb_dmres_bank: self-checking bench for the result register bank.
// assumes: host model on the byte port, bench drives the converter side.
`timescale 1ns/1ps
module tb_dmres_bank;
  logic        clk_sys_i = 1'b0;
  logic        reset_i   = 1'b1;
  logic        frz       = 1'b0;
  logic        vld       = 1'b0;
  logic [3:0]  chn       = 4'h0;
  logic [11:0] dat       = 12'h000;
  logic [7:0]  addr, wdata, rdata, b;
  logic        rd, wr, ack, hit, held, stray;
  int          n_mismatch = 0;
  int          checked    = 0;
  int          mdl [16];
  logic [31:0] seed = 32'h0000608A;
  logic [3:0]  id;
  always #25 clk_sys_i = ~clk_sys_i;
  dmres_host host (.clk_sys_i(clk_sys_i), .reg_addr_o(addr), .reg_rd_o(rd), .reg_wr_o(wr),
    .reg_wdata_o(wdata), .reg_rdata_i(rdata), .reg_ack_i(ack));
  dmres_bank uut (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .reg_addr_i(addr), .reg_rd_i(rd),
    .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_ack_o(ack), .reg_hit_o(hit),
    .freeze_monitor_results_i(frz), .result_valid_i(vld), .result_chan_i(chn),
    .result_data_i(dat), .results_held_o(held), .stray_result_o(stray));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  task automatic stop_test;
    if (n_mismatch == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : stop_test
  task automatic chk(input string n, input logic [11:0] e, input logic [11:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // access with missing answer counted and fatal to the run
  task automatic acc(input bit w, input logic [7:0] a, output logic [7:0] d);
    bit ok;
    host.acc(w, a, 8'(xs()), d, ok);
    chk("ack", 12'h001, {11'h000, ok});
    if (!ok)
      stop_test();
  endtask : acc
  task automatic send(input logic [3:0] c, input logic [11:0] d);
    @(posedge clk_sys_i);
    #1;
    vld = 1'b1;
    chn = c;
    dat = d;
    @(posedge clk_sys_i);
    #1;
    vld = 1'b0;
  endtask : send
  // every slot against the model, plus an unmapped place
  task automatic check_all;
    logic [7:0] h, l;
    for (int k = 0; k < dmres_pkg::NUM_SRC; k++) begin
      acc(1'b0, dmres_pkg::SLOT_HIGH_OFS[k], h);
      chk("hit", 12'h001, {11'h000, hit});
      acc(1'b0, dmres_pkg::SLOT_LOW_OFS[k], l);
      chk("hit", 12'h001, {11'h000, hit});
      chk("id", {8'h00, dmres_pkg::SLOT_ID[k]}, {8'h00, l[3:0]});
      chk("result", 12'(mdl[dmres_pkg::SLOT_ID[k]]), host.rebuild(h, l));
    end
    acc(1'b0, 8'h72, h);
    chk("unmapped", 12'h000, {4'h0, h});
    chk("hit", 12'h000, {11'h000, hit});
  endtask : check_all
  initial begin
    foreach (mdl[i]) mdl[i] = 0;
    repeat (3) @(posedge clk_sys_i);
    #1;
    reset_i = 1'b0;
    check_all();
    // random results, random freeze, one byte read straight after
    for (int k = 0; k < 27; k++) begin
      id  = dmres_pkg::SLOT_ID[k % 9];
      frz = (k % 3 == 1) ? 1'b0 : 1'(xs());
      dat = 12'(xs());
      send(id, dat);
      chk("held", {11'h000, frz}, {11'h000, held});
      if (!frz)
        mdl[id] = dat;
      acc(1'b0, (k / 9 == 1) ? dmres_pkg::SLOT_LOW_OFS[k % 9] : dmres_pkg::SLOT_HIGH_OFS[k % 9], b);
      chk("byte", (k / 9 == 1) ? 12'(((mdl[id] & 15) << 4) | id) : 12'(mdl[id] >> 4), {4'h0, b});
    end
    frz = 1'b0;
    // writes everywhere, then a result with an unknown id
    for (int k = 0; k < 18; k++) begin
      acc(1'b1, (k < 9) ? dmres_pkg::SLOT_HIGH_OFS[k] : dmres_pkg::SLOT_LOW_OFS[k - 9], b);
      chk("wr_rdata", 12'h000, {4'h0, b});
    end
    send(4'h2, 12'(xs()));
    @(posedge clk_sys_i);
    #1;
    chk("stray", 12'h001, {11'h000, stray});
    check_all();
    // reset in mid-run clears every loaded result
    reset_i = 1'b1;
    repeat (2) @(posedge clk_sys_i);
    #1;
    reset_i = 1'b0;
    foreach (mdl[i]) mdl[i] = 0;
    check_all();
    stop_test();
  end
endmodule : tb_dmres_bank
